// ---- vcrc_regs.sv ----
/*
  Register bank for the port VC status word, the VC resource 0 capability word and the
  VC resource 0 control word of one switch port, plus the traffic class map it drives.
  Assumes a single 10 MHz clock, a plain strobe port from a master on the same clock,
  and a static upstream strap pin that is settled before reset is released.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module vcrc_regs
  import vcrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic upstream_strap,
  input wire vcrc_req_t cfg_req,
  input wire logic [2:0] tc_query,
  output vcrc_rsp_t cfg_rsp,
  output logic [7:0] traffic_class_map,
  output logic tc_query_hit,
  output logic channel_enable,
  output logic port_is_upstream
);

  // **************************************************************************
  // Reset release and strap capture.
  // **************************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  wire logic strap_sync;

  vcrc_sync u_strap_sync (
    .clk(sys_clk),
    .rst_n(rst_n_reg),
    .ce(clk_en),
    .d(upstream_strap),
    .q(strap_sync)
  );

  // The strap is treated as a level that may change only across a reset, but it is
  // followed continuously so a late-settling pin still lands on the right values.
  logic upstream_reg;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      upstream_reg <= 1'b0;
    end else if (clk_en) begin
      upstream_reg <= strap_sync;
    end
  end

  // **************************************************************************
  // Address decode.
  // **************************************************************************
  wire vcrc_sel_t sel;

  assign sel = (cfg_req.addr == `VCRC_OFF_PORT_VC_STATUS) ? VCRC_SEL_STATUS :
               (cfg_req.addr == `VCRC_OFF_VC_RES0_CAP) ? VCRC_SEL_CAP :
               (cfg_req.addr == `VCRC_OFF_VC_RES0_CTL) ? VCRC_SEL_CTL :
               VCRC_SEL_NONE;

  // **************************************************************************
  // Fixed register images.
  // **************************************************************************
  wire logic [15:0] status_word;
  wire logic [7:0] scheme_flags;
  wire logic [7:0] table_offset;
  // Both words are built field by field in processes, so they are variables, not nets.
  logic [31:0] cap_word;
  logic [31:0] ctl_word;

  // Only VC0 exists, so the table can never be incoherent.
  assign status_word = `VCRC_STS_RESET;

  assign scheme_flags = upstream_reg ? `VCRC_SCHEMES_UP : `VCRC_SCHEMES_DOWN;
  assign table_offset = upstream_reg ? `VCRC_TBL_OFF_UP : `VCRC_TBL_OFF_DOWN;

  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[`VCRC_CAP_SCHEME_MSB:`VCRC_CAP_SCHEME_LSB] = scheme_flags;
    cap_word[`VCRC_CAP_ADV_SWITCH_BIT] = 1'b0;
    cap_word[`VCRC_CAP_SNOOP_REJECT_BIT] = 1'b0;
    cap_word[`VCRC_CAP_SLOTS_MSB:`VCRC_CAP_SLOTS_LSB] = `VCRC_MAX_SLOTS;
    cap_word[`VCRC_CAP_TBL_OFF_MSB:`VCRC_CAP_TBL_OFF_LSB] = table_offset;
  end

  // **************************************************************************
  // Traffic class map.
  // **************************************************************************
  logic [7:0] map_reg;
  wire logic [7:0] map_next;
  wire logic map_write;

  assign map_write = cfg_req.wr && (sel == VCRC_SEL_CTL);
  // Bit 0 is forced so class zero can never be unmapped by software.
  assign map_next = (cfg_req.wdata[7:0] & `VCRC_MAP_RW_MASK) | `VCRC_MAP_RO_MASK;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      map_reg <= `VCRC_MAP_RESET;
    end else if (clk_en && map_write) begin
      map_reg <= map_next;
    end
  end

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[`VCRC_CTL_MAP_MSB:`VCRC_CTL_MAP_LSB] = map_reg | `VCRC_MAP_RO_MASK;
    ctl_word[`VCRC_CTL_ENABLE_BIT] = 1'b1;
  end

  // **************************************************************************
  // Read answer.
  // **************************************************************************
  wire logic [31:0] rd_mux;
  vcrc_rsp_t rsp_reg;
  vcrc_rsp_t rsp_next;

  // Unmapped offsets read as zero; all writes outside the map bits are dropped.
  assign rd_mux = (sel == VCRC_SEL_STATUS) ? {16'h0000, status_word} :
                  (sel == VCRC_SEL_CAP) ? cap_word :
                  (sel == VCRC_SEL_CTL) ? ctl_word :
                  32'h0000_0000;

  always_comb begin
    rsp_next.rvalid = cfg_req.rd;
    rsp_next.rdata = cfg_req.rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rsp_reg <= '0;
    end else if (clk_en) begin
      rsp_reg <= rsp_next;
    end
  end

  // **************************************************************************
  // Map outputs toward the switch core.
  // **************************************************************************
  logic hit_reg;
  logic enable_reg;
  logic [7:0] map_out_reg;
  wire logic hit_next;

  assign hit_next = map_reg[tc_query] | (tc_query == 3'h0);

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hit_reg <= 1'b0;
      enable_reg <= 1'b0;
      map_out_reg <= `VCRC_MAP_RESET;
    end else if (clk_en) begin
      hit_reg <= hit_next;
      enable_reg <= 1'b1;
      map_out_reg <= map_reg | `VCRC_MAP_RO_MASK;
    end
  end

  assign cfg_rsp = rsp_reg;
  assign traffic_class_map = map_out_reg;
  assign tc_query_hit = hit_reg;
  assign channel_enable = enable_reg;
  assign port_is_upstream = upstream_reg;

endmodule

// ---- vcrc_defines.svh ----
/*
  Offsets, field positions, reset values and fixed field values of the VC resource 0
  register bank. Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef VCRC_DEFINES_SVH
`define VCRC_DEFINES_SVH

// ****************************************************************************
// Register offsets, as byte addresses on the configuration port.
// ****************************************************************************
`define VCRC_ADDR_W 12
`define VCRC_OFF_PORT_VC_STATUS 12'h20e
`define VCRC_OFF_VC_RES0_CAP 12'h210
`define VCRC_OFF_VC_RES0_CTL 12'h214

// ****************************************************************************
// Port VC status fields.
// ****************************************************************************
`define VCRC_STS_COHERENCY_BIT 0
`define VCRC_STS_RESET 16'h0000

// ****************************************************************************
// VC resource 0 capability fields.
// ****************************************************************************
`define VCRC_CAP_SCHEME_LSB 0
`define VCRC_CAP_SCHEME_MSB 7
`define VCRC_CAP_ADV_SWITCH_BIT 14
`define VCRC_CAP_SNOOP_REJECT_BIT 15
`define VCRC_CAP_SLOTS_LSB 16
`define VCRC_CAP_SLOTS_MSB 22
`define VCRC_CAP_TBL_OFF_LSB 24
`define VCRC_CAP_TBL_OFF_MSB 31
`define VCRC_SCHEMES_UP 8'h03
`define VCRC_SCHEMES_DOWN 8'h01
`define VCRC_TBL_OFF_UP 8'h02
`define VCRC_TBL_OFF_DOWN 8'h00
`define VCRC_MAX_SLOTS 7'h00

// ****************************************************************************
// VC resource 0 control fields.
// ****************************************************************************
`define VCRC_CTL_MAP_LSB 0
`define VCRC_CTL_MAP_MSB 7
`define VCRC_CTL_ENABLE_BIT 31
`define VCRC_MAP_RESET 8'hff
`define VCRC_MAP_RO_MASK 8'h01
`define VCRC_MAP_RW_MASK 8'hfe

`endif

// ---- vcrc_pkg.sv ----
/*
  Types shared by the VC resource 0 register bank: the configuration request and
  answer carriers and the decoded register selection.
  Assumes vcrc_defines.svh is on the include path.
*/
`include "vcrc_defines.svh"

package vcrc_pkg;

  typedef struct packed {
    logic [`VCRC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vcrc_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
  } vcrc_rsp_t;

  typedef enum logic [1:0] {
    VCRC_SEL_NONE,
    VCRC_SEL_STATUS,
    VCRC_SEL_CAP,
    VCRC_SEL_CTL
  } vcrc_sel_t;

endpackage

// ---- vcrc_sync.sv ----
/*
  Two-flop synchroniser for a single level coming from outside the clock domain.
  Assumes the caller supplies the already-released reset and the clock enable.
*/
`timescale 1ns/1ps

module vcrc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  logic meta_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- vcrc_regs_assertions.sv ----
/* Checker for the VC resource 0 register bank, bound to vcrc_regs.
   Assumes one clock, reads answered one enabled cycle after the strobe. */
`timescale 1ns/1ps
module vcrc_regs_assertions
  import vcrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic upstream_strap,
  input wire vcrc_req_t cfg_req,
  input wire logic [2:0] tc_query,
  input wire vcrc_rsp_t cfg_rsp,
  input wire logic [7:0] traffic_class_map,
  input wire logic tc_query_hit,
  input wire logic channel_enable,
  input wire logic port_is_upstream
);
  wire logic [11:0] a = cfg_req.addr;
  wire logic rd_go = cfg_req.rd && clk_en;
  wire logic wr_ctl = cfg_req.wr && clk_en && a == 12'h214;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_read_answered: assert property (rd_go |=> cfg_rsp.rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property ($past(clk_en) && !$past(cfg_req.rd) |-> !cfg_rsp.rvalid)
    else $error("answer without read");
  a_status_zero: assert property (rd_go && a == 12'h20e |=> cfg_rsp.rdata == 32'h0)
    else $error("status word not zero");
  a_cap_fixed: assert property (rd_go && a == 12'h210 |=>
    cfg_rsp.rdata == (port_is_upstream ? 32'h02000003 : 32'h00000001))
    else $error("capability word wrong");
  a_ctl_fixed: assert property (rd_go && a == 12'h214 |=>
    cfg_rsp.rdata[31:8] == 24'h800000 && cfg_rsp.rdata[0])
    else $error("control fixed bits wrong");
  a_map_write_read: assert property (wr_ctl ##1 (rd_go && a == 12'h214) |=>
    cfg_rsp.rdata[7:0] == ($past(cfg_req.wdata[7:0], 2) | 8'h01))
    else $error("map write lost");
  a_map_bit0: assert property (traffic_class_map[0])
    else $error("class zero unmapped");
  a_class0_hit: assert property (channel_enable && clk_en && tc_query == 3'h0 |=> tc_query_hit)
    else $error("class zero query missed");
  a_enable_holds: assert property (channel_enable |=> channel_enable)
    else $error("channel enable dropped");
  a_unmapped_zero: assert property (rd_go && !(a inside {12'h20e, 12'h210, 12'h214}) |=>
    cfg_rsp.rdata == 32'h0)
    else $error("unmapped read not zero");
  c_write_then_read: cover property (wr_ctl ##1 rd_go);
  c_cap_up: cover property (rd_go && a == 12'h210 && port_is_upstream);
  c_cap_down: cover property (rd_go && a == 12'h210 && !port_is_upstream);
endmodule
bind vcrc_regs vcrc_regs_assertions u_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .upstream_strap(upstream_strap), .cfg_req(cfg_req), .tc_query(tc_query), .cfg_rsp(cfg_rsp),
  .traffic_class_map(traffic_class_map), .tc_query_hit(tc_query_hit),
  .channel_enable(channel_enable), .port_is_upstream(port_is_upstream));

// ---- vcrc_regs_tb.sv ----
/* Self-checking bench for vcrc_regs, run once as a downstream and once as an upstream port.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
module vcrc_regs_tb
  import vcrc_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, upstream_strap = 1'b0;
  vcrc_req_t cfg_req = '0;
  logic [2:0] tc_query = 3'h0;
  vcrc_rsp_t cfg_rsp;
  logic [7:0] traffic_class_map;
  logic tc_query_hit, channel_enable, port_is_upstream;
  logic [31:0] d, e;
  integer seed = 32'h0fac8024, miscompares = 0, check_count = 0;
  vcrc_regs dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .upstream_strap(upstream_strap), .cfg_req(cfg_req), .tc_query(tc_query), .cfg_rsp(cfg_rsp),
    .traffic_class_map(traffic_class_map), .tc_query_hit(tc_query_hit),
    .channel_enable(channel_enable), .port_is_upstream(port_is_upstream));
  initial forever #50 sys_clk = ~sys_clk;
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // The task leaves the strobe up; the caller ends a burst with an idle op.
  task op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    cfg_req <= '{addr: a, wdata: dat, wr: w, rd: r};
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    op(1'b0, 1'b1, a, 32'h0);
    op(1'b0, 1'b0, 12'h0, 32'h0);
    #1 chk({cfg_rsp.rvalid, cfg_rsp.rdata}, {1'b1, exp});
  endtask
  function logic [31:0] cap_exp(input logic up);
    return up ? 32'h02000003 : 32'h00000001;
  endfunction
  function logic [31:0] ctl_exp(input logic [31:0] w);
    return {24'h800000, w[7:1], 1'b1};
  endfunction
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    // The strap is followed continuously but meant to change only across a reset, so each port kind gets its own reset.
    for (int up = 0; up < 2; up++) begin
      @(posedge sys_clk);
      resetn <= 1'b0;
      upstream_strap <= up[0];
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 chk({channel_enable, port_is_upstream}, {1'b1, up[0]});
      rd_chk(12'h20e, 32'h0);
      op(1'b1, 1'b0, 12'h20e, 32'hffffffff);
      rd_chk(12'h20e, 32'h0);
      rd_chk(12'h210, cap_exp(up[0]));
      op(1'b1, 1'b0, 12'h210, 32'hffffffff);
      rd_chk(12'h210, cap_exp(up[0]));
      rd_chk(12'h214, 32'h800000ff);
      rd_chk(12'h20c, 32'h0);
      for (int i = 0; i < 12; i++) begin
        d = (i == 0) ? 32'h0 : (i == 1) ? 32'hfffffffe : $random(seed);
        e = ctl_exp(d);
        op(1'b1, 1'b0, 12'h214, d);
        rd_chk(12'h214, e);
        for (int q = 0; q < 8; q++) begin
          @(posedge sys_clk);
          tc_query <= q[2:0];
          @(posedge sys_clk);
          #1 chk({tc_query_hit, traffic_class_map}, {e[q], e[7:0]});
        end
      end
      // A write offered while the clock enable is low must leave the map untouched.
      @(posedge sys_clk);
      clk_en <= 1'b0;
      cfg_req <= '{addr: 12'h214, wdata: 32'h0, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      cfg_req <= '0;
      clk_en <= 1'b1;
      rd_chk(12'h214, e);
    end
    give_verdict;
  end
endmodule
